// File: shared/la_pkg.sv
// constants, types and carriers for the logic analyzer trigger and capture block
//
// Function
// - cross trigger ports are build-time options
// - extra trigger modes use the input line
// - input-only mode triggers on rising edge
// - output source: off, result, input, or both
// - store only in pre, wait, post states
// - unconditional mode stores every allowed cycle
// - qualified mode stores when capture condition true
// - capture condition has its own selector
// - combine comparators by and, or, nand, nor
// - comparators: eq, ne, lt, le, gt, ge
// - buffer splits into equal power-of-two windows
// - each window keeps its own trigger mark
// - stop keeps only completely filled windows
// - windows arm, trigger, fill one after another
// - zero position may trigger right after window
// - nonzero position: pre samples, trigger, rest
// - triggers during pre-trigger fill are ignored
// - arm goes to wait when position zero
package la_pkg;
  localparam int PROBES = 4;
  localparam int PROBE_W = 8;
  localparam int AW = 10; // sample buffer address width
  localparam int CW = 11; // window count width
  localparam int BUF_DEPTH = 1024;
  localparam int SW = PROBES * PROBE_W;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WINDOWS = 8'h08;
  localparam logic [7:0] REG_TPOS = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_MARK_SEL = 8'h1C;
  localparam logic [7:0] REG_MARK = 8'h20;
  localparam logic [7:0] REG_PROBE0 = 8'h30; // one word per probe

  // field positions
  localparam int CTRL_TMODE = 0;
  localparam int CTRL_OMODE = 3;
  localparam int CTRL_CMODE = 5;
  localparam int CTRL_TCOND = 6;
  localparam int CTRL_CCOND = 8;
  localparam int CTRL_W = 10;
  localparam int CMD_ARM = 0;
  localparam int CMD_STOP = 1;
  localparam int WIN_DEPTH_LSB = 0; // log2 of window depth
  localparam int WIN_COUNT_LSB = 4; // log2 of window count
  localparam int WIN_LOG_W = 4;
  localparam int STAT_FILLED_LSB = 8;
  localparam int IRQ_TRIGGER = 0;
  localparam int IRQ_WINDOW = 1;
  localparam int IRQ_HALT = 2;
  localparam int IRQ_W = 3;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam logic [2*WIN_LOG_W-1:0] WIN_RESET = 8'h0A; // one window of full depth
  localparam logic [AW-1:0] TPOS_RESET = 10'h000;

  typedef enum logic [2:0] {
    basic_only_mode = 3'h0,
    sequencer_only_mode = 3'h1,
    basic_or_external_mode = 3'h2,
    sequencer_or_external_mode = 3'h3,
    external_edge_only_mode = 3'h4
  } trig_mode_type;

  typedef enum logic [1:0] {
    output_disabled = 2'h0,
    output_from_result = 2'h1,
    output_from_external = 2'h2,
    output_from_result_or_external = 2'h3
  } out_mode_type;

  typedef enum logic [1:0] {
    cond_and = 2'h0,
    cond_or = 2'h1,
    cond_nand = 2'h2,
    cond_nor = 2'h3
  } cond_type;

  typedef enum logic [2:0] {
    op_eq = 3'h0,
    op_ne = 3'h1,
    op_lt = 3'h2,
    op_le = 3'h3,
    op_gt = 3'h4,
    op_ge = 3'h5
  } cmp_op_type;

  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_pre = 5'b00010,
    st_wait = 5'b00100,
    st_post = 5'b01000,
    st_full = 5'b10000
  } state_type;

  // one probe's trigger and capture comparator settings
  typedef struct packed {
    logic cap_en;
    cmp_op_type cap_op;
    logic [PROBE_W-1:0] cap_val;
    logic trig_en;
    cmp_op_type trig_op;
    logic [PROBE_W-1:0] trig_val;
  } probe_cfg_type;

  // one sample write into the capture buffer
  typedef struct packed {
    logic we;
    logic [AW-1:0] addr;
    logic [SW-1:0] data;
  } sample_write_type;
endpackage

// File: src/probe_comparator.sv
// one probe comparator against a programmed value
`timescale 1ns/1ps
module probe_comparator
  import la_pkg::*;
(
  input wire logic [PROBE_W-1:0] probe,
  input wire logic [PROBE_W-1:0] value,
  input wire cmp_op_type op,
  output logic hit
);
  // relation select
  wire is_eq = (probe == value);
  wire is_lt = (probe < value);
  always_comb
  begin
    case (op)
      op_eq: hit = is_eq;
      op_ne: hit = !is_eq;
      op_lt: hit = is_lt;
      op_le: hit = is_lt || is_eq;
      op_gt: hit = !is_lt && !is_eq;
      op_ge: hit = !is_lt;
      default: hit = 1'b0;
    endcase
  end
endmodule // probe_comparator

// File: src/logic_analyzer_trigger_capture.sv
// trigger routing and capture control of the logic analyzer core
`timescale 1ns/1ps
module logic_analyzer_trigger_capture
  import la_pkg::*;
#(
  parameter bit CROSS_IN_PRESENT = 1'b1,
  parameter bit CROSS_OUT_PRESENT = 1'b1
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [SW-1:0] probe_in,
  input wire logic sequencer_trigger,
  input wire logic cross_trigger_input,
  output logic cross_trigger_input_acknowledge,
  output logic cross_trigger_output,
  input wire logic cross_trigger_output_acknowledge,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output sample_write_type sample_wr,
  output logic irq
);
  // register state
  logic [CTRL_W-1:0] ctrl_q;
  logic [2*WIN_LOG_W-1:0] win_cfg_q;
  logic [AW-1:0] tpos_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [CW-1:0] mark_sel_q;
  probe_cfg_type probe_cfg_q [PROBES];
  logic [31:0] reg_rdata_q;

  // capture state
  state_type state_q;
  state_type state_d;
  logic [AW-1:0] woff_q;
  logic [AW-1:0] woff_d;
  logic [AW-1:0] pre_q;
  logic [AW-1:0] pre_d;
  logic [AW-1:0] post_q;
  logic [AW-1:0] post_d;
  logic [CW-1:0] win_q;
  logic [CW-1:0] win_d;
  logic window_done;
  logic [AW-1:0] mark_mem [BUF_DEPTH];
  sample_write_type sample_wr_q;

  // cross trigger synchronisers and outputs
  logic [2:0] tin_sync_q;
  logic tin_lvl_q;
  logic tin_prev_q;
  logic [2:0] oack_sync_q;
  logic oack_lvl_q;
  logic tout_q;
  logic tin_ack_q;

  // field decode
  wire trig_mode_type tmode = trig_mode_type'(ctrl_q[CTRL_TMODE +: 3]);
  wire out_mode_type omode = out_mode_type'(ctrl_q[CTRL_OMODE +: 2]);
  wire cap_qualified = ctrl_q[CTRL_CMODE];
  wire cond_type tcond = cond_type'(ctrl_q[CTRL_TCOND +: 2]);
  wire cond_type ccond = cond_type'(ctrl_q[CTRL_CCOND +: 2]);
  wire [WIN_LOG_W-1:0] depth_log = win_cfg_q[WIN_DEPTH_LSB +: WIN_LOG_W];
  wire [WIN_LOG_W-1:0] count_log = win_cfg_q[WIN_COUNT_LSB +: WIN_LOG_W];

  // window geometry; base address wraps at AW bits, depth and count are not checked to fit the buffer
  wire [CW-1:0] depth_full = CW'(1) << depth_log;
  wire [CW-1:0] depth_m1 = depth_full - CW'(1);
  wire [AW-1:0] dmask = depth_m1[AW-1:0];
  wire [CW-1:0] win_count = CW'(1) << count_log;
  wire [AW-1:0] tpos = tpos_q & dmask;
  wire [CW-1:0] base_full = win_q << depth_log;
  wire [AW-1:0] wr_addr = base_full[AW-1:0] | woff_q;

  // bus decode
  wire wr_ctrl = reg_write && (reg_addr == REG_CTRL);
  wire wr_cmd = reg_write && (reg_addr == REG_CMD);
  wire wr_win = reg_write && (reg_addr == REG_WINDOWS);
  wire wr_tpos = reg_write && (reg_addr == REG_TPOS);
  wire wr_istat = reg_write && (reg_addr == REG_IRQ_STAT);
  wire wr_imask = reg_write && (reg_addr == REG_IRQ_MASK);
  wire wr_msel = reg_write && (reg_addr == REG_MARK_SEL);
  wire probe_hit = (reg_addr[7:4] == REG_PROBE0[7:4]);
  wire [1:0] probe_idx = reg_addr[3:2];
  wire arm = wr_cmd && reg_wdata[CMD_ARM];
  wire stop = wr_cmd && reg_wdata[CMD_STOP];

  // comparator banks, one trigger and one capture comparator per probe
  logic [PROBES-1:0] trig_hits;
  logic [PROBES-1:0] cap_hits;
  logic [PROBES-1:0] trig_ens;
  logic [PROBES-1:0] cap_ens;
  for (genvar i = 0; i < PROBES; i++)
  begin : g_probe
    probe_comparator u_trig (
      .probe(probe_in[i*PROBE_W +: PROBE_W]),
      .value(probe_cfg_q[i].trig_val),
      .op(probe_cfg_q[i].trig_op),
      .hit(trig_hits[i])
    );
    probe_comparator u_cap (
      .probe(probe_in[i*PROBE_W +: PROBE_W]),
      .value(probe_cfg_q[i].cap_val),
      .op(probe_cfg_q[i].cap_op),
      .hit(cap_hits[i])
    );
    assign trig_ens[i] = probe_cfg_q[i].trig_en;
    assign cap_ens[i] = probe_cfg_q[i].cap_en;
  end

  // global combination of participating comparators
  function automatic logic combine(input logic [PROBES-1:0] hit, input logic [PROBES-1:0] en,
                                   input cond_type c);
    logic r;
    r = 1'b0;
    case (c)
      cond_and: r = &(hit | ~en);
      cond_or: r = |(hit & en);
      cond_nand: r = |(~hit & en);
      cond_nor: r = &(~hit | ~en);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // trigger and capture conditions, each with its own selector
  wire basic_hit = combine(trig_hits, trig_ens, tcond);
  wire cap_hit = combine(cap_hits, cap_ens, ccond);

  // input line and its rising edge; absent input reads low
  wire ext_lvl = CROSS_IN_PRESENT && tin_lvl_q;
  wire ext_rise = ext_lvl && !tin_prev_q;

  // trigger result by mode
  logic trig_result;
  always_comb
  begin
    case (tmode)
      basic_only_mode: trig_result = basic_hit;
      sequencer_only_mode: trig_result = sequencer_trigger;
      basic_or_external_mode: trig_result = basic_hit || ext_lvl;
      sequencer_or_external_mode: trig_result = sequencer_trigger || ext_lvl;
      external_edge_only_mode: trig_result = ext_rise;
      default: trig_result = 1'b0;
    endcase
  end

  // capture gating: pre, wait and post only, then per cycle qualification
  wire capturing = (state_q == st_pre) || (state_q == st_wait) || (state_q == st_post);
  wire store = capturing && (!cap_qualified || cap_hit);
  wire fire = (state_q == st_wait) && trig_result;
  wire [AW-1:0] woff_inc = (woff_q + AW'(1)) & dmask;
  wire [AW-1:0] pre_inc = pre_q + AW'(1);
  wire [AW-1:0] post_len = dmask - tpos;
  wire [CW-1:0] win_inc = win_q + CW'(1);
  wire rearm_state_pre = (tpos != AW'(0));

  // output source select
  logic out_src;
  always_comb
  begin
    case (omode)
      output_disabled: out_src = 1'b0;
      output_from_result: out_src = fire;
      output_from_external: out_src = ext_lvl;
      output_from_result_or_external: out_src = fire || ext_lvl;
      default: out_src = 1'b0;
    endcase
  end

  // capture sequencer next state
  always_comb
  begin
    state_d = state_q;
    woff_d = woff_q;
    pre_d = pre_q;
    post_d = post_q;
    win_d = win_q;
    window_done = 1'b0;
    case (state_q)
      st_idle, st_full:
      begin
        if (arm)
        begin
          woff_d = AW'(0);
          pre_d = AW'(0);
          win_d = CW'(0);
          state_d = rearm_state_pre ? st_pre : st_wait;
        end
      end
      st_pre:
      begin
        if (store)
        begin
          woff_d = woff_inc;
          pre_d = pre_inc;
          if (pre_inc == tpos)
            state_d = st_wait;
        end
      end
      st_wait:
      begin
        if (store)
          woff_d = woff_inc;
        if (fire)
        begin
          post_d = post_len;
          if (post_len == AW'(0))
            window_done = 1'b1;
          else
            state_d = st_post;
        end
      end
      st_post:
      begin
        if (store)
        begin
          woff_d = woff_inc;
          post_d = post_q - AW'(1);
          if (post_q == AW'(1))
            window_done = 1'b1;
        end
      end
      default: state_d = st_idle;
    endcase
    // a filled window advances and re-arms, or ends the capture
    if (window_done)
    begin
      win_d = win_inc;
      woff_d = AW'(0);
      pre_d = AW'(0);
      if (win_inc == win_count)
        state_d = st_full;
      else
        state_d = rearm_state_pre ? st_pre : st_wait;
    end
    // stop halts; win keeps the count of completely filled windows
    if (stop && capturing)
    begin
      state_d = st_full;
    end
  end

  // capture sequencer registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= st_idle;
      woff_q <= AW'(0);
      pre_q <= AW'(0);
      post_q <= AW'(0);
      win_q <= CW'(0);
    end
    else
    begin
      state_q <= state_d;
      woff_q <= woff_d;
      pre_q <= pre_d;
      post_q <= post_d;
      win_q <= win_d;
    end
  end

  // per window trigger mark: offset of the trigger sample
  always_ff @(posedge core_clk)
  begin
    if (fire)
      mark_mem[win_q[AW-1:0]] <= woff_q;
  end

  // sample write port toward the capture buffer
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      sample_wr_q <= '0;
    else
      sample_wr_q <= '{we: store, addr: wr_addr, data: probe_in};
  end

  // cross trigger synchronisers, input is taken once stages two and three agree
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tin_sync_q <= 3'h0;
      oack_sync_q <= 3'h0;
      tin_lvl_q <= 1'b0;
      oack_lvl_q <= 1'b0;
      tin_prev_q <= 1'b0;
    end
    else
    begin
      tin_sync_q <= {tin_sync_q[1:0], cross_trigger_input};
      oack_sync_q <= {oack_sync_q[1:0], cross_trigger_output_acknowledge};
      if (tin_sync_q[1] == tin_sync_q[2])
        tin_lvl_q <= tin_sync_q[2];
      if (oack_sync_q[1] == oack_sync_q[2])
        oack_lvl_q <= oack_sync_q[2];
      tin_prev_q <= tin_lvl_q;
    end
  end

  // output held until acknowledged; a new event wins over the clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tout_q <= 1'b0;
      tin_ack_q <= 1'b0;
    end
    else
    begin
      tout_q <= CROSS_OUT_PRESENT && (out_src || (tout_q && !oack_lvl_q));
      tin_ack_q <= ext_lvl;
    end
  end

  // software registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= CTRL_RESET;
      win_cfg_q <= WIN_RESET;
      tpos_q <= TPOS_RESET;
      irq_mask_q <= '0;
      mark_sel_q <= CW'(0);
      for (int i = 0; i < PROBES; i++)
        probe_cfg_q[i] <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata[CTRL_W-1:0];
      if (wr_win)
        win_cfg_q <= reg_wdata[2*WIN_LOG_W-1:0];
      if (wr_tpos)
        tpos_q <= reg_wdata[AW-1:0];
      if (wr_imask)
        irq_mask_q <= reg_wdata[IRQ_W-1:0];
      if (wr_msel)
        mark_sel_q <= reg_wdata[CW-1:0];
      if (reg_write && probe_hit)
        probe_cfg_q[probe_idx] <= reg_wdata[$bits(probe_cfg_type)-1:0];
    end
  end

  // sticky events, write one to clear, a new event wins
  wire halted_evt = (state_d == st_full) && (state_q != st_full);
  wire [IRQ_W-1:0] irq_evt = {halted_evt, window_done, fire};
  wire [IRQ_W-1:0] irq_clr = wr_istat ? reg_wdata[IRQ_W-1:0] : '0;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
  end

  // read data selection
  wire [31:0] rd_probe = 32'(probe_cfg_q[probe_idx]);
  wire [31:0] rd_status = 32'({win_q, 3'h0, state_q});
  wire [31:0] rd_mark = 32'(mark_mem[mark_sel_q[AW-1:0]]);
  wire [31:0] rd_mux =
    (reg_addr == REG_CTRL) ? 32'(ctrl_q) :
    (reg_addr == REG_WINDOWS) ? 32'(win_cfg_q) :
    (reg_addr == REG_TPOS) ? 32'(tpos_q) :
    (reg_addr == REG_STATUS) ? rd_status :
    (reg_addr == REG_IRQ_STAT) ? 32'(irq_stat_q) :
    (reg_addr == REG_IRQ_MASK) ? 32'(irq_mask_q) :
    (reg_addr == REG_MARK_SEL) ? 32'(mark_sel_q) :
    (reg_addr == REG_MARK) ? rd_mark :
    probe_hit ? rd_probe : 32'h0000_0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata_q <= 32'h0000_0000;
    else
      reg_rdata_q <= reg_read ? rd_mux : 32'h0000_0000;
  end

  // outputs
  assign reg_rdata = reg_rdata_q;
  assign sample_wr = sample_wr_q;
  assign irq = |(irq_stat_q & irq_mask_q);
  assign cross_trigger_output = tout_q;
  assign cross_trigger_input_acknowledge = CROSS_IN_PRESENT && tin_ack_q;
endmodule // logic_analyzer_trigger_capture

// File: dv/la_props.sv
// port checker of the trigger and capture block, with its bind
`timescale 1ns/1ps
module la_props
  import la_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [SW-1:0] probe_in,
  input wire logic sequencer_trigger,
  input wire logic cross_trigger_input,
  input wire logic cross_trigger_input_acknowledge,
  input wire logic cross_trigger_output,
  input wire logic cross_trigger_output_acknowledge,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire sample_write_type sample_wr,
  input wire logic irq
);
  logic [1:0] omode_q;
  logic [7:0] win_q;
  logic [2:0] mask_q;
  logic cap_q;
  logic [4:0] in_h_q;
  logic [4:0] ack_h_q;
  // register writes shadowed here
  wire ctl_wr = reg_write && reg_addr == REG_CTRL;
  wire win_wr = reg_write && reg_addr == REG_WINDOWS;
  wire msk_wr = reg_write && reg_addr == REG_IRQ_MASK;
  wire cmd_wr = reg_write && reg_addr == REG_CMD;
  // shadows and short histories of the async handshake lines
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      omode_q <= 2'h0;
      win_q <= WIN_RESET;
      mask_q <= 3'h0;
      cap_q <= 1'b0;
      in_h_q <= 5'h00;
      ack_h_q <= 5'h00;
    end
    else
    begin
      if (ctl_wr)
        omode_q <= reg_wdata[CTRL_OMODE+:2];
      if (win_wr)
        win_q <= reg_wdata[7:0];
      if (msk_wr)
        mask_q <= reg_wdata[2:0];
      if (cmd_wr)
        cap_q <= reg_wdata[CMD_ARM] | (cap_q & ~reg_wdata[CMD_STOP]);
      in_h_q <= {in_h_q[3:0], cross_trigger_input};
      ack_h_q <= {ack_h_q[3:0], cross_trigger_output_acknowledge};
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // input held long enough to pass the synchroniser
  sequence in_high6;
    cross_trigger_input [*6];
  endsequence
  AST_IN_ACK_LEVEL: assert property (in_high6 |-> cross_trigger_input_acknowledge)
    else $error("input acknowledge missing");
  AST_IN_ACK_CAUSE: assert property ($rose(cross_trigger_input_acknowledge) |-> |in_h_q)
    else $error("input acknowledge without input");
  AST_OUT_HOLD: assert property ($fell(cross_trigger_output) |-> |ack_h_q)
    else $error("trigger output dropped before acknowledge");
  AST_OUT_OFF: assert property ($rose(cross_trigger_output) |-> $past(omode_q) != output_disabled)
    else $error("trigger output rose while disabled");
  AST_OUT_PASS: assert property ((cross_trigger_input && omode_q == output_from_external) [*6] |-> cross_trigger_output)
    else $error("input not passed to trigger output");
  AST_WE_DATA: assert property (sample_wr.we |-> sample_wr.data == $past(probe_in))
    else $error("stored sample differs from probes");
  AST_WE_CAPTURE: assert property (sample_wr.we |-> cap_q || $past(cap_q) || $past(cap_q, 2))
    else $error("sample stored while not capturing");
  AST_WE_RANGE: assert property (sample_wr.we |-> (int'(sample_wr.addr) >> win_q[3:0]) < (1 << win_q[7:4]))
    else $error("sample address outside windows");
  AST_IRQ_MASK: assert property (mask_q == 3'h0 |-> !irq)
    else $error("interrupt with all events masked");
endmodule // la_props

bind logic_analyzer_trigger_capture la_props props (.core_clk, .resetn, .probe_in, .sequencer_trigger,
  .cross_trigger_input, .cross_trigger_input_acknowledge, .cross_trigger_output, .cross_trigger_output_acknowledge,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sample_wr, .irq);

// File: dv/xtrig_partner.sv
// far-side logic: drives the cross trigger input and acknowledges the output
`timescale 1ns/1ps
module xtrig_partner
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic fire,
  input wire logic [7:0] hold_len,
  input wire logic [3:0] ack_lag,
  input wire logic cross_trigger_output,
  output logic cross_trigger_input,
  output logic cross_trigger_output_acknowledge
);
  logic [7:0] hold_q;
  logic [3:0] lag_q;
  // one input pulse of hold_len plus one cycles per fire request
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_q <= 8'h00;
      cross_trigger_input <= 1'b0;
    end
    else if (fire)
    begin
      hold_q <= hold_len;
      cross_trigger_input <= 1'b1;
    end
    else if (hold_q != 8'h00)
      hold_q <= hold_q - 8'h01;
    else
      cross_trigger_input <= 1'b0;
  end
  // acknowledge after ack_lag cycles, held until the output drops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn || !cross_trigger_output)
    begin
      lag_q <= 4'h0;
      cross_trigger_output_acknowledge <= 1'b0;
    end
    else if (lag_q == ack_lag)
      cross_trigger_output_acknowledge <= 1'b1;
    else
      lag_q <= lag_q + 4'h1;
  end
endmodule // xtrig_partner

// File: dv/tb_top.sv
// testbench of the trigger and capture block
`timescale 1ns/1ps
module tb_top
  import la_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [SW-1:0] probe_in = '0;
  logic sequencer_trigger = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic fire = 1'b0;
  logic [7:0] hold_len = 8'h08;
  logic [3:0] ack_lag = 4'h1;
  logic cross_trigger_input, cross_trigger_input_acknowledge;
  logic cross_trigger_output, cross_trigger_output_acknowledge;
  logic [31:0] reg_rdata;
  sample_write_type sample_wr;
  logic irq;
  logic [31:0] v;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int out_n = 0;
  logic [AW-1:0] aq[$];
  logic [7:0] dq[$];
  int tq[$];
  logic_analyzer_trigger_capture dut (.core_clk, .resetn, .probe_in, .sequencer_trigger, .cross_trigger_input,
    .cross_trigger_input_acknowledge, .cross_trigger_output, .cross_trigger_output_acknowledge,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sample_wr, .irq);
  xtrig_partner peer (.core_clk, .resetn, .fire, .hold_len, .ack_lag, .cross_trigger_output,
    .cross_trigger_input, .cross_trigger_output_acknowledge);
  always #2 core_clk = ~core_clk;
  // probe counter and sample and output monitors
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    probe_in <= probe_in + 32'h0101_0101;
    if (cross_trigger_output === 1'b1)
      out_n <= out_n + 1;
    if (sample_wr.we === 1'b1)
    begin
      aq.push_back(sample_wr.addr);
      dq.push_back(sample_wr.data[7:0]);
      tq.push_back(cyc);
    end
  end
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task setup(input logic [31:0] ctl, input logic [31:0] win, input logic [31:0] tp);
    wr(REG_CTRL, ctl);
    wr(REG_WINDOWS, win);
    wr(REG_TPOS, tp);
    wr(REG_IRQ_STAT, 32'h7);
    aq.delete();
    dq.delete();
    tq.delete();
  endtask
  task wait_full;
    for (int i = 0; i < 700; i++)
    begin
      rd(REG_STATUS, v);
      if (v[4:0] === st_full)
        return;
    end
    err_count++;
    $display("Error at %0t: capture never full", $time);
  endtask
  task pulse(input logic [7:0] n);
    @(posedge core_clk);
    hold_len <= n;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask
  // comparator relation against 8'h40 and the combination of one probe
  function automatic logic pred(input int op, input int c, input logic [7:0] x);
    logic h;
    h = (op == 0) ? x == 8'h40 : (op == 1) ? x != 8'h40 : (op == 2) ? x < 8'h40 :
        (op == 3) ? x <= 8'h40 : (op == 4) ? x > 8'h40 : x >= 8'h40;
    return (c >= 2) ? !h : h;
  endfunction
  task t_reset;
    rd(REG_CTRL, v);
    chk32(v, 32'h0000_0000);
    rd(REG_WINDOWS, v);
    chk32(v, 32'h0000_000A);
    rd(REG_STATUS, v);
    chk32(v, 32'h0000_0001);
    rd(8'hFC, v);
    chk32(v, 32'h0000_0000);
    $display("test reset values done");
  endtask
  task t_windows;
    int n;
    setup(32'h1, 32'h12, 32'h0);
    wr(REG_CMD, 32'h1);
    rd(REG_STATUS, v);
    chk32(v, 32'h0000_0004);
    sequencer_trigger <= 1'b1;
    wait_full;
    sequencer_trigger <= 1'b0;
    chk32(v, 32'h0000_0210);
    n = aq.size();
    for (int k = 0; k < 4; k++)
      chk32(aq[n-4+k], 32'(4 + k));
    chk32(tq[n-4] - tq[n-5], 32'h1);
    wr(REG_MARK_SEL, 32'h1);
    rd(REG_MARK, v);
    chk32(v, 32'h0000_0000);
    $display("test window sequence done");
  endtask
  task t_pretrig;
    setup(32'h1, 32'h02, 32'h2);
    @(posedge core_clk);
    reg_addr <= REG_CMD;
    reg_wdata <= 32'h1;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    sequencer_trigger <= 1'b1;
    @(posedge core_clk);
    sequencer_trigger <= 1'b0;
    rd(REG_STATUS, v);
    chk32(v, 32'h0000_0004);
    chk32(aq[0], 32'h0);
    chk32(aq[1], 32'h1);
    sequencer_trigger <= 1'b1;
    wait_full;
    sequencer_trigger <= 1'b0;
    chk32(v, 32'h0000_0110);
    $display("test pre-trigger done");
  endtask
  task t_qual;
    for (int o = 0; o < 6; o++)
      for (int c = 0; c < 4; c++)
      begin
        setup(32'h21 | ((3 - c) << CTRL_TCOND) | (c << CTRL_CCOND), 32'h02, 32'h0);
        wr(REG_PROBE0, 32'h0080_0000 | (o << 20) | 32'h0004_0000);
        wr(REG_CMD, 32'h1);
        sequencer_trigger <= 1'b1;
        wait_full;
        sequencer_trigger <= 1'b0;
        chk1(dq.size() > 0, 1'b1);
        foreach (dq[i])
          chk1(pred(o, c, dq[i]), 1'b1);
      end
    $display("test qualified capture done");
  endtask
  task t_cross;
    int n0;
    for (int m = 2; m < 5; m++)
    begin
      setup(m, 32'h02, 32'h0);
      wr(REG_PROBE0, 32'h0000_0CFF);
      wr(REG_CMD, 32'h1);
      rd(REG_STATUS, v);
      chk32(v, 32'h0000_0004);
      pulse(8'h08);
      wait_full;
      chk32(v, 32'h0000_0110);
    end
    setup(32'h4, 32'h02, 32'h0);
    pulse(8'h3C);
    repeat (10) @(posedge core_clk);
    wr(REG_CMD, 32'h1);
    repeat (20) @(posedge core_clk);
    rd(REG_STATUS, v);
    chk32(v, 32'h0000_0004);
    repeat (40) @(posedge core_clk);
    pulse(8'h08);
    wait_full;
    chk32(v, 32'h0000_0110);
    for (int m = 0; m < 4; m++)
    begin
      ack_lag <= 4'(3 * m);
      wr(REG_CTRL, m << CTRL_OMODE);
      n0 = out_n;
      pulse(8'h08);
      repeat (40) @(posedge core_clk);
      chk1(out_n > n0, m[1]);
      chk1(cross_trigger_output, 1'b0);
    end
    $display("test cross trigger done");
  endtask
  task t_stop;
    setup(32'h1, 32'h12, 32'h0);
    wr(REG_CMD, 32'h1);
    rd(REG_STATUS, v);
    sequencer_trigger <= 1'b1;
    @(posedge core_clk);
    sequencer_trigger <= 1'b0;
    repeat (12) @(posedge core_clk);
    wr(REG_CMD, 32'h2);
    rd(REG_STATUS, v);
    chk32(v, 32'h0000_0110);
    chk1(irq, 1'b0);
    rd(REG_IRQ_STAT, v);
    chk32(v, 32'h0000_0007);
    wr(REG_IRQ_MASK, 32'h4);
    #1;
    chk1(irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h7);
    #1;
    chk1(irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h0);
    $display("test stop and interrupt done");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset;
    t_windows;
    t_pretrig;
    t_qual;
    t_cross;
    t_stop;
    finish_test;
  end
  // watchdog sized well above the expected run
  initial
  begin
    #200000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule // tb_top
